// *** core/lvdc_core.sv ***
// low-voltage detect control: mode registers, detection filter, reset and interrupt
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: source_select picks supply or external sense comparison
// RL2: action_select 1 holds reset while below
// RL3: action_select 0 pulses interrupt on both crossings
// RL4: sixteen supply levels; external reference fixed
// RL5: below_threshold_flag bit 0, read-only, zero when disabled
// RL6: monitor reset sets monitor_reset_cause_flag
// RL7: source bit 2, action bit 1, bits 6..3 zero
// RL8: monitor_enable bit 7 starts or stops monitoring
// RL9: other resets clear control; monitor reset keeps it
// RL10: software waits stabilization after enabling monitor
// RL11: flag sets at least 200 us after drop
// RL12: control at ffbe, bit and byte writes
// RL13: monitoring continues during stop mode
// RL14: level register ffbf kept over monitor reset
// RL15: disabling while below in interrupt mode interrupts
// RL16: synchronize comparator; one pulse per crossing
module lvdc_core #(
    parameter int FILTER_CYCLES = lvdc_pkg::FILTER_CYCLES
) (
    // clock and non-monitor reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // cpu bus
    input wire lvdc_pkg::lvdc_bus_req_t bus_req,
    output logic [7:0] bus_rdata_q,
    // analog comparator side
    input wire logic supply_below_raw,
    input wire logic ext_below_raw,
    output logic comparator_enable_q,
    output logic [lvdc_pkg::LVL_W-1:0] threshold_level_q,
    // system side
    input wire logic cause_clear,
    output logic monitor_reset_q,
    output logic monitor_interrupt_q,
    output logic monitor_reset_cause_flag_q
);
    //////////////////////////////////////////////////////////////////////////////////////
    // byte or single-bit write onto an 8-bit register
    function automatic logic [7:0] apply_write(input logic [7:0] old,
                                               input lvdc_pkg::lvdc_bus_req_t req);
        logic [7:0] res;
        res = old;
        if (req.wr)
        begin
            res = req.wdata;
        end
        else if (req.bit_wr)
        begin
            res[req.bit_sel] = req.wdata[0];
        end
        return res;
    endfunction

    logic enable_q;
    logic source_q;
    logic action_q;
    logic flag_q;
    logic flag_d;
    logic [lvdc_pkg::CNT_W-1:0] cnt_q;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic below_sel;
    logic ctl_hit;
    logic lvl_hit;
    logic [7:0] ctl_view;
    logic [7:0] ctl_new;
    logic [7:0] lvl_new;
    localparam logic [lvdc_pkg::CNT_W-1:0] CNT_MAX = lvdc_pkg::CNT_W'(FILTER_CYCLES);

    assign ctl_hit = (bus_req.wr || bus_req.bit_wr) && bus_req.addr == lvdc_pkg::CTL_ADDR;
    assign lvl_hit = (bus_req.wr || bus_req.bit_wr) && bus_req.addr == lvdc_pkg::LVL_ADDR;

    always_comb
    begin
        ctl_view = lvdc_pkg::READ_ZERO;
        ctl_view[lvdc_pkg::ENABLE_BIT] = enable_q;
        ctl_view[lvdc_pkg::SOURCE_BIT] = source_q;
        ctl_view[lvdc_pkg::ACTION_BIT] = action_q;
        ctl_view[lvdc_pkg::FLAG_BIT] = flag_q;
    end
    assign ctl_new = apply_write(ctl_view, bus_req);
    assign lvl_new = apply_write({4'h0, threshold_level_q}, bus_req);

    //////////////////////////////////////////////////////////////////////////////////////
    // control register; only reset_n clears it, the monitor reset never reaches here
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable_q <= lvdc_pkg::CTL_RESET[lvdc_pkg::ENABLE_BIT]; // [RL9]
            source_q <= lvdc_pkg::CTL_RESET[lvdc_pkg::SOURCE_BIT];
            action_q <= lvdc_pkg::CTL_RESET[lvdc_pkg::ACTION_BIT];
        end
        else if (ctl_hit) // [RL12]
        begin
            enable_q <= ctl_new[lvdc_pkg::ENABLE_BIT]; // [RL8]
            source_q <= ctl_new[lvdc_pkg::SOURCE_BIT]; // [RL7]
            action_q <= ctl_new[lvdc_pkg::ACTION_BIT];
        end
    end

    // level select; ignored by the external path, whose reference is fixed
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            threshold_level_q <= lvdc_pkg::LVL_RESET[lvdc_pkg::LVL_W-1:0]; // [RL14]
        end
        else if (lvl_hit)
        begin
            threshold_level_q <= lvl_new[lvdc_pkg::LVL_W-1:0]; // [RL4]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            comparator_enable_q <= 1'b0;
        end
        else
        begin
            comparator_enable_q <= enable_q; // [RL8]
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // comparator outputs are asynchronous; no gating by stop mode keeps them live
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= gi == 0 ? supply_below_raw : ext_below_raw; // [RL16]
                    sync2_q[gi] <= sync1_q[gi]; // [RL13]
                end
            end
        end
    endgenerate

    assign below_sel = source_q ? sync2_q[1] : sync2_q[0]; // [RL1]

    // filter counter: flag only after a full run of below samples
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= '0;
        end
        else if (!enable_q || !below_sel)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q != CNT_MAX)
        begin
            cnt_q <= cnt_q + 1'b1; // [RL11]
        end
    end

    assign flag_d = enable_q && below_sel && cnt_q == CNT_MAX; // [RL5] [RL11]

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // a flag edge caused by disabling still interrupts, as software expects
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            monitor_interrupt_q <= 1'b0;
        end
        else
        begin
            monitor_interrupt_q <= (flag_d != flag_q) && !action_q; // [RL3] [RL15] [RL16]
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            monitor_reset_q <= 1'b0;
        end
        else
        begin
            monitor_reset_q <= flag_d && action_q; // [RL2]
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            monitor_reset_cause_flag_q <= 1'b0;
        end
        else if (flag_d && action_q)
        begin
            monitor_reset_cause_flag_q <= 1'b1; // [RL6]
        end
        else if (cause_clear)
        begin
            monitor_reset_cause_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_rdata_q <= lvdc_pkg::READ_ZERO;
        end
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                lvdc_pkg::CTL_ADDR: bus_rdata_q <= ctl_view; // [RL7]
                lvdc_pkg::LVL_ADDR: bus_rdata_q <= {4'h0, threshold_level_q};
                default: bus_rdata_q <= lvdc_pkg::READ_ZERO;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    flag_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL5]
        !enable_q |=> !flag_q) else $error("flag set while disabled");
    filter_min_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL11]
        $rose(flag_q) |-> $past(cnt_q) == CNT_MAX && $past(below_sel))
        else $error("flag set before filter time");
    src_pick_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL1]
        enable_q && source_q && !sync2_q[1] |=> !flag_q)
        else $error("flag follows unselected input");
    reset_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL2]
        flag_q && enable_q && action_q && below_sel |=> monitor_reset_q)
        else $error("monitor reset not held");
    no_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL3]
        !action_q |=> !monitor_reset_q) else $error("reset in interrupt mode");
    irq_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL3]
        !action_q && flag_d != flag_q |=> monitor_interrupt_q)
        else $error("crossing without interrupt");
    disable_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL15]
        $fell(enable_q) && flag_q && !action_q |=> monitor_interrupt_q)
        else $error("disable while below gave no interrupt");
    cause_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL6]
        $rose(monitor_reset_q) |-> monitor_reset_cause_flag_q)
        else $error("cause flag not set");
    ctl_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL12]
        bus_req.wr && bus_req.addr == lvdc_pkg::CTL_ADDR |=>
        enable_q == $past(bus_req.wdata[lvdc_pkg::ENABLE_BIT])
        && source_q == $past(bus_req.wdata[lvdc_pkg::SOURCE_BIT])
        && action_q == $past(bus_req.wdata[lvdc_pkg::ACTION_BIT]))
        else $error("control byte write lost");
    ctl_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL7]
        bus_req.rd && bus_req.addr == lvdc_pkg::CTL_ADDR |=>
        bus_rdata_q[lvdc_pkg::ENABLE_BIT-1:lvdc_pkg::SOURCE_BIT+1] == '0)
        else $error("reserved control bits nonzero");
    lvl_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL14]
        !lvl_hit |=> $stable(threshold_level_q)) else $error("level changed unwritten");
endmodule

// *** core/lvdc_pkg.sv ***
// constants and carrier types for the low-voltage detect control block
package lvdc_pkg;
    // register addresses on the cpu memory bus
    localparam logic [15:0] CTL_ADDR = 16'hffbe;
    localparam logic [15:0] LVL_ADDR = 16'hffbf;
    // control register field positions
    localparam int ENABLE_BIT = 7;
    localparam int SOURCE_BIT = 2;
    localparam int ACTION_BIT = 1;
    localparam int FLAG_BIT = 0;
    localparam int LVL_W = 4;
    // reset values after any reset other than a monitor reset
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] LVL_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // detection delay: least time from below-threshold to flag set
    localparam int CLK_MHZ = 40;
    localparam int FILTER_TIME_US = 200;
    localparam int FILTER_CYCLES = FILTER_TIME_US * CLK_MHZ;
    localparam int CNT_W = 14;
    // cpu access request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic rd;
    } lvdc_bus_req_t;
endpackage

// *** test/lvdc_cmp_model.sv ***
// behavioural comparator facing the detect control block
`timescale 1ns/1ps
module lvdc_cmp_model (
    // analog stimulus, a higher step is a lower supply voltage
    input wire logic [4:0] supply_step,
    input wire logic ext_low,
    // from the block
    input wire logic comparator_enable_q,
    input wire logic [3:0] threshold_level_q,
    // to the block
    output logic supply_below_raw,
    output logic ext_below_raw
);
    // a stopped comparator idles low, so stale results never leak through
    assign supply_below_raw = comparator_enable_q
        && (supply_step > {1'b0, threshold_level_q});
    assign ext_below_raw = comparator_enable_q && ext_low;
endmodule

// *** test/tb.sv ***
// self-checking bench for the low-voltage detect control block
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module tb;
    localparam int FC = 20;
    localparam logic [15:0] CTL = lvdc_pkg::CTL_ADDR;
    localparam logic [15:0] LVL = lvdc_pkg::LVL_ADDR;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    lvdc_pkg::lvdc_bus_req_t req = '0;
    logic [7:0] rdata;
    logic sup_raw, ext_raw, cmp_en, irq, mrst, cause;
    logic cause_clear = 1'b0;
    logic ext_low = 1'b0;
    logic [3:0] lvl;
    logic [4:0] supply_step = 5'h00;
    int n_errors = 0;
    int samples_checked = 0;
    int n;
    ////////////////////////////////////////////////////////////
    lvdc_core #(.FILTER_CYCLES(FC)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_req(req), .bus_rdata_q(rdata), .supply_below_raw(sup_raw),
        .ext_below_raw(ext_raw), .comparator_enable_q(cmp_en), .threshold_level_q(lvl),
        .cause_clear(cause_clear), .monitor_reset_q(mrst), .monitor_interrupt_q(irq),
        .monitor_reset_cause_flag_q(cause));
    lvdc_cmp_model cmp_u (.supply_step(supply_step), .ext_low(ext_low),
        .comparator_enable_q(cmp_en), .threshold_level_q(lvl),
        .supply_below_raw(sup_raw), .ext_below_raw(ext_raw));
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bit_mode);
        @(posedge ref_clk);
        req.addr <= a;
        req.wdata <= bit_mode ? {7'h00, d[0]} : d;
        req.bit_sel <= d[6:4];
        req.wr <= !bit_mode;
        req.bit_wr <= bit_mode;
        @(posedge ref_clk);
        req.wr <= 1'b0;
        req.bit_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    function automatic logic sig(input int k);
        sig = (k == 0) ? irq : mrst;
    endfunction
    // bounded wait; running out of the bound ends the run
    task automatic wt(input int k, input logic v, input int lim);
        n = 0;
        while (sig(k) !== v && n < lim)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (sig(k) !== v)
        begin
            n_errors++;
            results();
        end
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rdc(CTL, 8'h00);
        rdc(LVL, 8'h00);
        rdc(16'hff00, 8'h00);
        wr(CTL, 8'hff, 1'b0);
        rdc(CTL, 8'h86);
        `CHK(cmp_en, 1'b1)
        wr(LVL, 8'hff, 1'b0);
        rdc(LVL, 8'h0f);
        `CHK(lvl, 4'hf)
        wr(LVL, 8'h05, 1'b0);
        wr(CTL, 8'h80, 1'b0);
        repeat (400) @(posedge ref_clk);
        supply_step <= 5'h08;
        wt(0, 1'b1, FC + 40);
        `CHK(n >= FC, 1'b1)
        `CHK(mrst, 1'b0)
        rdc(CTL, 8'h81);
        supply_step <= 5'h02;
        wt(0, 1'b1, 20);
        rdc(CTL, 8'h80);
        wr(CTL, 8'h86, 1'b0);
        ext_low <= 1'b1;
        wt(1, 1'b1, FC + 40);
        `CHK(cause, 1'b1)
        rdc(CTL, 8'h87);
        ext_low <= 1'b0;
        supply_step <= 5'h08;
        wt(1, 1'b0, 10);
        repeat (FC + 10) @(posedge ref_clk);
        `CHK(mrst, 1'b0)
        cause_clear <= 1'b1;
        @(posedge ref_clk);
        cause_clear <= 1'b0;
        #1 `CHK(cause, 1'b0)
        wr(CTL, 8'h80, 1'b0);
        wt(0, 1'b1, FC + 40);
        wr(CTL, 8'h70, 1'b1);
        wt(0, 1'b1, 4);
        rdc(CTL, 8'h00);
        `CHK(cmp_en, 1'b0)
        wr(CTL, 8'h21, 1'b1);
        wr(CTL, 8'h11, 1'b1);
        rdc(CTL, 8'h06);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        reset_n <= 1'b1;
        rdc(CTL, 8'h00);
        rdc(LVL, 8'h00);
        results();
    end
endmodule
